// ---- pdc_clock_ctrl.sv ----
/*
 * pdc_clock_ctrl: system clock synthesizer and divider control.
 * Models the synthesizer output rate as an enable stream, applies the
 * post divider or its bypass, derives the CAN clock enable, watches lock
 * and clock loss, and holds the control registers behind AXI4-Lite.
 * Assumes aclk is the reference clock; the loss and lock inputs and the
 * CAN source select come from other domains and are synchronised here.
 */
// Our own choice: the AXI4-Lite register port.
// Overview of operation
// - synth rate = ref*mult/((prediv+1)*2^(div+1))
// - second synth register, output divider resets 11
// - CAN uses system path when source bit set
// - halve bit: CAN at full or half rate
// - bypass bit skips the post divider
// - divide select 00..11 gives /2../16
// - post divider output has 50% duty
// - post divider also slows alternative sources
// - system divider register, all zero at reset

`timescale 1ns/1ns
module pdc_clock_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins from the synthesizer and CAN controller
	input wire logic pll_locked_pin, // synthesizer lock indicator
	input wire logic ref_clock_lost_pin, // reference clock monitor
	input wire logic can_clock_source_select, // 1 selects bus clock
	// clock enables and status out
	output logic sys_clk_en, // system clock enable pulse
	output logic sys_clk_level, // system clock as a level
	output logic can_clk_en, // CAN controller clock enable
	output logic reset_request, // pulse toward reset control
	output logic irq // level interrupt
);
	// decode an address to a register index, used by both paths
	function automatic pdc_pkg::pdc_reg_idx_t decode_addr(input logic [31:0] addr);
		case (addr)
			pdc_pkg::ADDR_SYS_DIV_CTRL: decode_addr = pdc_pkg::PDC_REG_SYS_DIV;
			pdc_pkg::ADDR_SRC_CTRL: decode_addr = pdc_pkg::PDC_REG_SRC;
			pdc_pkg::ADDR_SYNTH_FIRST: decode_addr = pdc_pkg::PDC_REG_FIRST;
			pdc_pkg::ADDR_SYNTH_SECOND: decode_addr = pdc_pkg::PDC_REG_SECOND;
			pdc_pkg::ADDR_IRQ_STATUS: decode_addr = pdc_pkg::PDC_REG_STATUS;
			pdc_pkg::ADDR_IRQ_MASK: decode_addr = pdc_pkg::PDC_REG_MASK;
			default: decode_addr = pdc_pkg::PDC_REG_NONE;
		endcase
	endfunction : decode_addr

	// apply byte strobes, then keep only writable bits
	function automatic logic [31:0] merge_write(input logic [31:0] old_val,
		input logic [31:0] data, input logic [3:0] strb, input logic [31:0] wmask);
		logic [31:0] merged;
		merged = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merged[8*i +: 8] = data[8*i +: 8];
			end
		end
		merge_write = (merged & wmask) | (old_val & ~wmask);
	endfunction : merge_write

	// bus side state
	logic aw_held_reg; // address taken, waiting on data
	logic w_held_reg; // data taken, waiting on address
	logic [31:0] aw_addr_reg; // captured write address
	logic [31:0] w_data_reg; // captured write data
	logic [3:0] w_strb_reg; // captured write strobes
	logic do_write; // both halves present, commit now
	pdc_pkg::pdc_reg_idx_t wr_idx; // decoded write target
	pdc_pkg::pdc_reg_idx_t rd_idx; // decoded read target

	// control registers
	logic [31:0] sys_div_reg; // system divider control
	logic [31:0] src_ctrl_reg; // source select, writable part
	logic [31:0] synth_first_reg; // predivider and multiplier
	logic [31:0] synth_second_reg; // output divider and loss enables
	logic [2:0] irq_status_reg; // sticky events
	logic [2:0] irq_mask_reg; // interrupt enables per event

	// synchronisers, first stage read only by the second
	logic locked_s1_reg, locked_s2_reg, locked_prev_reg;
	logic lost_s1_reg, lost_s2_reg, lost_prev_reg;
	logic can_src_s1_reg, can_src_s2_reg;

	// event strobes, combinational from synchronised levels
	logic lock_loss_evt;
	logic lock_gain_evt;
	logic clock_loss_evt;
	logic [2:0] irq_set;

	// rate model
	logic [pdc_pkg::ACC_W-1:0] acc_reg; // phase accumulator
	logic [pdc_pkg::ACC_W-1:0] acc_sum; // accumulator plus multiplier
	logic [pdc_pkg::ACC_W-1:0] rate_thresh; // (prediv+1) * 2^(div+1)
	logic pll_tick; // synthesizer output enable
	logic src_tick; // chosen source enable
	logic post_tick; // post divider output enable
	logic post_level; // post divider output level
	logic can_half_reg; // toggles on each system tick

	assign wr_idx = decode_addr(aw_addr_reg);
	assign rd_idx = decode_addr(s_axi_araddr);
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

	// write address channel, one write in flight at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 32'h00000000;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end else if (!aw_held_reg && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1; // reopen once the response is gone
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end else if (!w_held_reg && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response, error for an unmapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pdc_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (wr_idx == pdc_pkg::PDC_REG_NONE) begin
				s_axi_bresp <= pdc_pkg::RESP_SLVERR;
			end else begin
				s_axi_bresp <= pdc_pkg::RESP_OKAY;
			end
		end else if (s_axi_bready && s_axi_bvalid) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// system divider register, only three fields writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_div_reg <= pdc_pkg::SD_RESET;
		end else if (do_write && wr_idx == pdc_pkg::PDC_REG_SYS_DIV) begin
			sys_div_reg <= merge_write(sys_div_reg, w_data_reg, w_strb_reg,
				(32'h1 << pdc_pkg::SD_CAN_HALVE_BIT) | (32'h1 << pdc_pkg::SD_BYPASS_BIT)
				| (32'h3 << pdc_pkg::SD_POST_SEL_LSB));
		end
	end

	// source select register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_ctrl_reg <= pdc_pkg::SC_RESET;
		end else if (do_write && wr_idx == pdc_pkg::PDC_REG_SRC) begin
			src_ctrl_reg <= merge_write(src_ctrl_reg, w_data_reg, w_strb_reg,
				pdc_pkg::SC_WRITE_MASK);
		end
	end

	// first synthesizer register, new rate takes effect at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			synth_first_reg <= pdc_pkg::S1_RESET;
		end else if (do_write && wr_idx == pdc_pkg::PDC_REG_FIRST) begin
			synth_first_reg <= merge_write(synth_first_reg, w_data_reg, w_strb_reg,
				pdc_pkg::S1_WRITE_MASK);
		end
	end

	// second synthesizer register, enables all off at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			synth_second_reg <= pdc_pkg::S2_RESET;
		end else if (do_write && wr_idx == pdc_pkg::PDC_REG_SECOND) begin
			synth_second_reg <= merge_write(synth_second_reg, w_data_reg, w_strb_reg,
				pdc_pkg::S2_WRITE_MASK);
		end
	end

	// interrupt mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_reg <= pdc_pkg::IRQ_RESET;
		end else if (do_write && wr_idx == pdc_pkg::PDC_REG_MASK && w_strb_reg[0]) begin
			irq_mask_reg <= w_data_reg[pdc_pkg::IRQ_WIDTH-1:0];
		end
	end

	// sticky status, a new event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= pdc_pkg::IRQ_RESET;
		end else if (do_write && wr_idx == pdc_pkg::PDC_REG_STATUS && w_strb_reg[0]) begin
			irq_status_reg <= (irq_status_reg & ~w_data_reg[pdc_pkg::IRQ_WIDTH-1:0]) | irq_set;
		end else begin
			irq_status_reg <= irq_status_reg | irq_set;
		end
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= pdc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pdc_pkg::RESP_OKAY;
			case (rd_idx)
				pdc_pkg::PDC_REG_SYS_DIV: s_axi_rdata <= sys_div_reg;
				pdc_pkg::PDC_REG_SRC: begin
					// live state shows beside the writable select
					s_axi_rdata <= src_ctrl_reg
						| (32'(locked_s2_reg) << pdc_pkg::SC_LOCKED_BIT)
						| (32'(lost_s2_reg) << pdc_pkg::SC_CLK_LOST_BIT)
						| (32'(can_src_s2_reg) << pdc_pkg::SC_CAN_SRC_BIT);
				end
				pdc_pkg::PDC_REG_FIRST: s_axi_rdata <= synth_first_reg;
				pdc_pkg::PDC_REG_SECOND: s_axi_rdata <= synth_second_reg;
				pdc_pkg::PDC_REG_STATUS: s_axi_rdata <= {29'h0, irq_status_reg};
				pdc_pkg::PDC_REG_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= pdc_pkg::RESP_SLVERR; // unmapped
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// two-stage synchronisers for the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			locked_s1_reg <= 1'b0;
			locked_s2_reg <= 1'b0;
			lost_s1_reg <= 1'b0;
			lost_s2_reg <= 1'b0;
			can_src_s1_reg <= 1'b0;
			can_src_s2_reg <= 1'b0;
		end else begin
			locked_s1_reg <= pll_locked_pin;
			locked_s2_reg <= locked_s1_reg;
			lost_s1_reg <= ref_clock_lost_pin;
			lost_s2_reg <= lost_s1_reg;
			can_src_s1_reg <= can_clock_source_select;
			can_src_s2_reg <= can_src_s1_reg;
		end
	end

	// previous values for edge detection, from the second stage only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			locked_prev_reg <= 1'b0;
			lost_prev_reg <= 1'b0;
		end else begin
			locked_prev_reg <= locked_s2_reg;
			lost_prev_reg <= lost_s2_reg;
		end
	end

	// events; clock loss is only seen while its detector is enabled
	always_comb begin
		lock_loss_evt = locked_prev_reg && !locked_s2_reg;
		lock_gain_evt = !locked_prev_reg && locked_s2_reg;
		clock_loss_evt = !lost_prev_reg && lost_s2_reg
			&& synth_second_reg[pdc_pkg::S2_LOC_EN_BIT];
		irq_set = 3'h0;
		irq_set[pdc_pkg::IRQ_LOCK_LOSS_BIT] = lock_loss_evt
			&& synth_second_reg[pdc_pkg::S2_LOL_IRQ_BIT];
		irq_set[pdc_pkg::IRQ_CLOCK_LOSS_BIT] = clock_loss_evt
			&& synth_second_reg[pdc_pkg::S2_LOC_IRQ_BIT];
		irq_set[pdc_pkg::IRQ_LOCK_GAIN_BIT] = lock_gain_evt;
	end

	// reset request and interrupt line, both registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_request <= 1'b0;
			irq <= 1'b0;
		end else begin
			reset_request <= (lock_loss_evt && synth_second_reg[pdc_pkg::S2_LOL_RE_BIT])
				|| (clock_loss_evt && synth_second_reg[pdc_pkg::S2_LOC_RE_BIT]);
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// rate model: tick rate is mult over threshold of the reference
	always_comb begin
		rate_thresh = pdc_pkg::ACC_W'(({8'h0, synth_first_reg[pdc_pkg::S1_PREDIV_LSB +: 4]}
			+ 12'h001) << ({1'b0, synth_second_reg[pdc_pkg::S2_OUT_DIV_LSB +: 2]}
			+ 3'h1));
		acc_sum = acc_reg + pdc_pkg::ACC_W'(synth_first_reg[pdc_pkg::S1_MULT_LSB +: 8]);
	end

	// ratios above one saturate at a tick every cycle; aclk is the limit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_reg <= '0;
			pll_tick <= 1'b0;
		end else if (acc_sum >= rate_thresh) begin
			acc_reg <= (acc_sum - rate_thresh >= rate_thresh) ? '0 : acc_sum - rate_thresh;
			pll_tick <= 1'b1;
		end else begin
			acc_reg <= acc_sum;
			pll_tick <= 1'b0;
		end
	end

	// source before the post divider: synthesizer or reference
	assign src_tick = src_ctrl_reg[pdc_pkg::SC_SRC_SEL_BIT] ? 1'b1 : pll_tick;

	// post divider, also applied to the reference path
	pdc_post_div u_post_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(src_tick),
		.div_sel(sys_div_reg[pdc_pkg::SD_POST_SEL_LSB +: 2]),
		.tick_out(post_tick),
		.clk_level(post_level)
	);

	// bypass picks the undivided stream; level then mirrors the tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk_en <= 1'b0;
			sys_clk_level <= 1'b0;
		end else if (sys_div_reg[pdc_pkg::SD_BYPASS_BIT]) begin
			sys_clk_en <= src_tick;
			sys_clk_level <= src_tick;
		end else begin
			sys_clk_en <= post_tick;
			sys_clk_level <= post_level;
		end
	end

	// CAN halving toggle, counts system ticks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			can_half_reg <= 1'b0;
		end else if (sys_clk_en) begin
			can_half_reg <= ~can_half_reg;
		end
	end

	// CAN enable; software must set halving above the CAN limit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			can_clk_en <= 1'b0;
		end else if (can_src_s2_reg) begin
			if (sys_div_reg[pdc_pkg::SD_CAN_HALVE_BIT]) begin
				can_clk_en <= sys_clk_en && can_half_reg;
			end else begin
				can_clk_en <= sys_clk_en;
			end
		end else begin
			can_clk_en <= 1'b1; // oscillator path runs at the reference
		end
	end

endmodule : pdc_clock_ctrl

// ---- pdc_pkg.sv ----
/*
 * pdc_pkg: shared constants for the system clock synthesizer and divider
 * control block. Register byte addresses, field positions, reset values,
 * bus response codes and the interrupt status layout.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package pdc_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_SYS_DIV_CTRL = 32'h000009A0; // system divider control
	localparam logic [31:0] ADDR_SRC_CTRL = 32'h000009A4; // clock source and live state
	localparam logic [31:0] ADDR_SYNTH_FIRST = 32'hC3F80008; // predivider and multiplier
	localparam logic [31:0] ADDR_SYNTH_SECOND = 32'hC3F8000C; // output divider, loss enables
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'hC3F80010; // sticky events, write one clears
	localparam logic [31:0] ADDR_IRQ_MASK = 32'hC3F80014; // interrupt mask

	// register index after decode
	typedef enum logic [2:0] {
		PDC_REG_NONE = 3'h0,
		PDC_REG_SYS_DIV = 3'h1,
		PDC_REG_SRC = 3'h2,
		PDC_REG_FIRST = 3'h3,
		PDC_REG_SECOND = 3'h4,
		PDC_REG_STATUS = 3'h5,
		PDC_REG_MASK = 3'h6
	} pdc_reg_idx_t;

	// system divider control fields
	localparam int SD_CAN_HALVE_BIT = 16; // can_clock_halve
	localparam int SD_BYPASS_BIT = 4; // post divider bypass
	localparam int SD_POST_SEL_LSB = 2; // post_divide_select [3:2]
	localparam logic [31:0] SD_RESET = 32'h00000000;

	// second synthesizer control fields
	localparam int S2_LOC_EN_BIT = 23; // clock_loss_detect_enable
	localparam int S2_LOL_RE_BIT = 22; // lock_loss_reset_enable
	localparam int S2_LOC_RE_BIT = 21; // clock_loss_reset_enable
	localparam int S2_LOL_IRQ_BIT = 20; // lock_loss_interrupt_enable
	localparam int S2_LOC_IRQ_BIT = 19; // clock_loss_interrupt_enable
	localparam int S2_OUT_DIV_LSB = 0; // pll_output_divider [1:0]
	localparam logic [31:0] S2_RESET = 32'h00000003;
	localparam logic [31:0] S2_WRITE_MASK = 32'h00F80003;

	// first synthesizer control fields
	localparam int S1_PREDIV_LSB = 16; // pll_input_predivider [19:16]
	localparam int S1_MULT_LSB = 0; // pll_feedback_multiplier [7:0]
	localparam logic [31:0] S1_RESET = 32'h00000008;
	localparam logic [31:0] S1_WRITE_MASK = 32'h000F00FF;

	// source control fields
	localparam int SC_SRC_SEL_BIT = 0; // 0 pll, 1 reference directly
	localparam int SC_LOCKED_BIT = 8; // live lock state, read only
	localparam int SC_CLK_LOST_BIT = 9; // live clock loss, read only
	localparam int SC_CAN_SRC_BIT = 10; // live can_clock_source_select
	localparam logic [31:0] SC_RESET = 32'h00000000;
	localparam logic [31:0] SC_WRITE_MASK = 32'h00000001;

	// interrupt status layout
	localparam int IRQ_LOCK_LOSS_BIT = 0;
	localparam int IRQ_CLOCK_LOSS_BIT = 1;
	localparam int IRQ_LOCK_GAIN_BIT = 2;
	localparam int IRQ_WIDTH = 3;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// accumulator width for the rate model
	localparam int ACC_W = 12;

endpackage : pdc_pkg

// ---- pdc_post_div.sv ----
/*
 * pdc_post_div: post divider for the system clock enable stream.
 * Divides incoming ticks by 2, 4, 8 or 16 with a 50 percent level output.
 * Assumes tick_in is a one-cycle enable on aclk.
 */
`timescale 1ns/1ns
module pdc_post_div (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick_in, // undivided enable
	input wire logic [1:0] div_sel, // 00 /2 .. 11 /16
	output logic tick_out, // one pulse per divided period
	output logic clk_level // divided clock, 50 percent duty
);
	logic [3:0] half_cnt_reg; // ticks seen in this half period
	logic [3:0] half_last; // last count of a half period

	// half period is 2^sel ticks, so both halves are equal
	always_comb begin
		half_last = 4'((4'h1 << div_sel) - 4'h1);
	end

	// count ticks and flip the level at each half period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_cnt_reg <= 4'h0;
			clk_level <= 1'b0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (half_cnt_reg >= half_last) begin
					// a ratio change lands cleanly here, never mid-count past the end
					half_cnt_reg <= 4'h0;
					clk_level <= ~clk_level;
					tick_out <= ~clk_level; // rising edge of the divided clock
				end else begin
					half_cnt_reg <= half_cnt_reg + 4'h1;
				end
			end
		end
	end

endmodule : pdc_post_div

// ---- pdc_clock_ctrl_monitor.sv ----
/* pdc_clock_ctrl_monitor: timing checks on the clock control block ports.
   Assumes one clock domain and a synchronous active low reset. */
`timescale 1ns/1ns
module pdc_clock_ctrl_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic can_clock_source_select,
	input wire logic can_clk_en,
	input wire logic reset_request
);
	// every check shares the bus clock and its reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	chk_aw_one_flight: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("second write address accepted");
	chk_ar_one_flight: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
		else $error("second read address accepted");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_reset_pulse: assert property ($rose(reset_request) |=> !reset_request)
		else $error("reset request wider than one cycle");
	chk_can_ref_clock: assert property ((!can_clock_source_select) [*5] |=> can_clk_en)
		else $error("reference CAN clock not running");
endmodule : pdc_clock_ctrl_monitor

bind pdc_clock_ctrl pdc_clock_ctrl_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.can_clock_source_select(can_clock_source_select), .can_clk_en(can_clk_en),
	.reset_request(reset_request));

// ---- pdc_ref_osc_model.sv ----
/* pdc_ref_osc_model: synthesizer lock, reference monitor and CAN source select.
   Assumes the bench commands each pin; lock only follows after settling. */
`timescale 1ns/1ns
module pdc_ref_osc_model (
	input wire logic aclk,
	input wire logic lock_cmd, // loop powered and steady
	input wire logic lost_cmd, // reference stops
	input wire logic can_bus_cmd, // CAN takes the bus clock
	output logic pll_locked_pin = 1'b0,
	output logic ref_clock_lost_pin = 1'b0,
	output logic can_clock_source_select = 1'b0
);
	int settle = 0; // cycles since the loop was enabled

	// lock is never reported before the loop has settled
	always @(posedge aclk) begin
		if (!lock_cmd) begin
			settle <= 0;
			pll_locked_pin <= 1'b0;
		end else if (settle < 20) begin
			settle <= settle + 1;
		end else begin
			pll_locked_pin <= 1'b1;
		end
	end

	// peripheral side levels, changed just after an edge
	always @(posedge aclk) begin
		ref_clock_lost_pin <= lost_cmd;
		can_clock_source_select <= can_bus_cmd;
	end
endmodule : pdc_ref_osc_model

// ---- pdc_clock_ctrl_tb_top.sv ----
/* pdc_clock_ctrl_tb_top: register, clock rate and interrupt tests.
   Assumes a 100 ns clock and the oscillator model on the pin side. */
`timescale 1ns/1ns
module pdc_clock_ctrl_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sys_en, sys_lvl, can_en, rst_req, irq;
	logic [1:0] bresp, rresp;
	logic locked, lost, can_sel; // model pins
	logic lock_cmd = 1'b1, lost_cmd = 1'b0, can_cmd = 1'b1;
	int fails = 0, n_compared = 0, cycles = 0, rst_seen = 0;

	always #50 aclk = ~aclk;

	pdc_clock_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pll_locked_pin(locked), .ref_clock_lost_pin(lost), .can_clock_source_select(can_sel),
		.sys_clk_en(sys_en), .sys_clk_level(sys_lvl), .can_clk_en(can_en),
		.reset_request(rst_req), .irq(irq));
	pdc_ref_osc_model u_osc (.aclk(aclk), .lock_cmd(lock_cmd), .lost_cmd(lost_cmd),
		.can_bus_cmd(can_cmd), .pll_locked_pin(locked), .ref_clock_lost_pin(lost),
		.can_clock_source_select(can_sel));

	task conclude;
		if (fails == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude

	// hang guard; also counts reset requests
	always @(posedge aclk) begin
		cycles++;
		if (rst_req === 1'b1) rst_seen++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// counts are measured, so allow up to tol-1 pulses of phase slip
	task near(input int got, input int exp, input int tol);
		if (got > exp - tol && got < exp + tol) chk(got, got);
		else chk(got, exp);
	endtask : near

	task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				done = 1'b1;
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
	endtask : wr

	task rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				done = 1'b1;
				rready <= 1'b0;
				chk(rdata, exp);
				chk({30'h0, rresp}, {30'h0, er});
			end
		end
	endtask : rd

	// program the divider, let it settle, count pulses over 256 cycles
	task rate(input logic [31:0] sd, input int es, input int ec);
		int s, c, l;
		s = 0; c = 0; l = 0;
		wr(pdc_pkg::ADDR_SYS_DIV_CTRL, sd, pdc_pkg::RESP_OKAY);
		repeat (40) @(negedge aclk);
		repeat (256) begin
			@(negedge aclk);
			if (sys_en === 1'b1) s++;
			if (can_en === 1'b1) c++;
			if (sys_lvl === 1'b1) l++;
		end
		near(s, es, 3);
		near(c, ec, 3);
		if (!sd[4]) near(l, 128, 17);
	endtask : rate

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(pdc_pkg::ADDR_SYS_DIV_CTRL, 32'h00000000, pdc_pkg::RESP_OKAY);
		rd(pdc_pkg::ADDR_SYNTH_SECOND, 32'h00000003, pdc_pkg::RESP_OKAY);
		rd(pdc_pkg::ADDR_SYNTH_FIRST, 32'h00000008, pdc_pkg::RESP_OKAY);
		wr(pdc_pkg::ADDR_SYS_DIV_CTRL, 32'hFFFFFFFF, pdc_pkg::RESP_OKAY);
		rd(pdc_pkg::ADDR_SYS_DIV_CTRL, 32'h0001001C, pdc_pkg::RESP_OKAY);
		wr(pdc_pkg::ADDR_SYNTH_SECOND, 32'hFFFFFFFF, pdc_pkg::RESP_OKAY);
		rd(pdc_pkg::ADDR_SYNTH_SECOND, 32'h00F80003, pdc_pkg::RESP_OKAY);
		wr(pdc_pkg::ADDR_SYNTH_SECOND, 32'h00000003, pdc_pkg::RESP_OKAY);
		rd(32'h00000100, 32'h00000000, pdc_pkg::RESP_SLVERR);
		wr(32'h00000100, 32'h00000001, pdc_pkg::RESP_SLVERR);
		// reference straight in: one tick per cycle
		wr(pdc_pkg::ADDR_SRC_CTRL, 32'h00000001, pdc_pkg::RESP_OKAY);
		for (int k = 0; k < 4; k++) rate(k << 2, 256 >> (k + 1), 256 >> (k + 1));
		rate(32'h00000010, 256, 256);
		rate(32'h00010010, 256, 128);
		can_cmd <= 1'b0;
		rate(32'h00010010, 256, 256);
		can_cmd <= 1'b1;
		// synthesizer path: 8/(1*16) then 6/(2*4) ticks per cycle
		wr(pdc_pkg::ADDR_SRC_CTRL, 32'h00000000, pdc_pkg::RESP_OKAY);
		rate(32'h00000010, 128, 128);
		rate(32'h00000000, 64, 64);
		wr(pdc_pkg::ADDR_SYNTH_FIRST, 32'h00010006, pdc_pkg::RESP_OKAY);
		wr(pdc_pkg::ADDR_SYNTH_SECOND, 32'h00000001, pdc_pkg::RESP_OKAY);
		rate(32'h00000010, 192, 192);
		// lock loss with reset and interrupt enabled, masked first
		wr(pdc_pkg::ADDR_IRQ_STATUS, 32'h00000007, pdc_pkg::RESP_OKAY);
		wr(pdc_pkg::ADDR_SYNTH_SECOND, 32'h00500003, pdc_pkg::RESP_OKAY);
		lock_cmd <= 1'b0;
		repeat (10) @(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		chk(rst_seen, 1);
		rd(pdc_pkg::ADDR_IRQ_STATUS, 32'h00000001, pdc_pkg::RESP_OKAY);
		wr(pdc_pkg::ADDR_IRQ_MASK, 32'h00000001, pdc_pkg::RESP_OKAY);
		repeat (3) @(negedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(pdc_pkg::ADDR_IRQ_STATUS, 32'h00000001, pdc_pkg::RESP_OKAY);
		repeat (3) @(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		// clock loss with detector, reset and interrupt enabled
		wr(pdc_pkg::ADDR_SYNTH_SECOND, 32'h00A80003, pdc_pkg::RESP_OKAY);
		lost_cmd <= 1'b1;
		repeat (10) @(negedge aclk);
		chk(rst_seen, 32'h2);
		rd(pdc_pkg::ADDR_IRQ_STATUS, 32'h00000002, pdc_pkg::RESP_OKAY);
		// live state: unlocked, reference lost, CAN on the bus clock
		rd(pdc_pkg::ADDR_SRC_CTRL, 32'h00000600, pdc_pkg::RESP_OKAY);
		conclude();
	end
endmodule : pdc_clock_ctrl_tb_top
